// >>> verilog/crlc_top.v
// Comparator reference ladder control: register file over AXI4-Lite and
// the digital controls steering the analog ladder, source and pin muxes.
// Assumes a single 200 MHz clock; the analog ladder sits outside.
`timescale 1ns/10ps
`default_nettype none
`include "crlc_consts.vh"

module crlc_top (
   // Clock and reset
   input  wire        REF_CLK,
   input  wire        SYS_RST,
   // AXI4-Lite write address
   input  wire [3:0]  S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output wire        S_AXI_AWREADY,
   // AXI4-Lite write data
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output wire        S_AXI_WREADY,
   // AXI4-Lite write response
   output reg  [1:0]  S_AXI_BRESP,
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   // AXI4-Lite read address
   input  wire [3:0]  S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output wire        S_AXI_ARREADY,
   // AXI4-Lite read data
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY,
   // Ladder analog controls
   output reg         LADDER_POWER_ON,
   output reg         RANGE_LOW_SELECT,
   output reg         SOURCE_EXTERNAL_SELECT,
   output reg  [15:0] LADDER_TAP_SELECT,
   // Pin and comparator muxes
   output reg         PORT_F_PIN5_REF_CONNECT,
   output reg         COMP_VINP_FROM_LADDER,
   // Sleep state, for status only
   input  wire        SLEEP_ACTIVE
);

   // One-hot decode of the 4-bit tap code
   function [15:0] tap_onehot;
      input [3:0] code;
      begin
         tap_onehot = 16'h0001 << code;
      end
   endfunction

   reg  [7:0]  ladder_ctrl_reg;
   reg  [7:0]  portf_dir_reg;
   reg  [2:0]  comp_mode_reg;
   reg  [3:0]  aw_addr_reg;
   reg         aw_held_reg;
   reg  [31:0] w_data_reg;
   reg  [3:0]  w_strb_reg;
   reg         w_held_reg;

   wire [3:0]  tap_code = ladder_ctrl_reg[`CRLC_TAP_MSB:0];

   // Address and data are each taken once and held until the response
   assign S_AXI_AWREADY = !aw_held_reg && !S_AXI_BVALID;
   assign S_AXI_WREADY  = !w_held_reg && !S_AXI_BVALID;
   assign S_AXI_ARREADY = !S_AXI_RVALID;

   wire do_write = aw_held_reg && w_held_reg && !S_AXI_BVALID;

   function known_addr;
      input [3:0] a;
      begin
         known_addr = (a == `CRLC_OFS_LADDER_CTRL) || (a == `CRLC_OFS_PORTF_DIR) ||
                      (a == `CRLC_OFS_COMP_MODE) || (a == `CRLC_OFS_STATUS);
      end
   endfunction

   // Write channel capture and register update
   always @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         aw_addr_reg     <= 4'h0;
         aw_held_reg     <= 1'b0;
         w_data_reg      <= 32'h0000_0000;
         w_strb_reg      <= 4'h0;
         w_held_reg      <= 1'b0;
         S_AXI_BVALID    <= 1'b0;
         S_AXI_BRESP     <= 2'h0;
         // R7 R8 clear whole control
         ladder_ctrl_reg <= `CRLC_RST_LADDER_CTRL;
         portf_dir_reg   <= `CRLC_RST_PORTF_DIR;
         comp_mode_reg   <= `CRLC_RST_COMP_MODE;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_addr_reg <= {S_AXI_AWADDR[3:2], 2'b00};
            aw_held_reg <= 1'b1;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
            w_held_reg <= 1'b1;
         end
         if (do_write) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= known_addr(aw_addr_reg) ? `CRLC_RESP_OKAY : `CRLC_RESP_SLVERR;
            // Only byte lane 0 carries data; other lanes are ignored
            if (w_strb_reg[0]) begin
               case (aw_addr_reg)
                  // R9 no sleep side effect
                  `CRLC_OFS_LADDER_CTRL: ladder_ctrl_reg <= w_data_reg[7:0];
                  `CRLC_OFS_PORTF_DIR:   portf_dir_reg   <= w_data_reg[7:0];
                  `CRLC_OFS_COMP_MODE:   comp_mode_reg   <= w_data_reg[2:0];
                  default: ;
               endcase
            end
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // Read channel: one cycle to data
   always @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h0000_0000;
         S_AXI_RRESP  <= 2'h0;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP  <= known_addr({S_AXI_ARADDR[3:2], 2'b00}) ? `CRLC_RESP_OKAY : `CRLC_RESP_SLVERR;
         case ({S_AXI_ARADDR[3:2], 2'b00})
            `CRLC_OFS_LADDER_CTRL: S_AXI_RDATA <= {24'h000000, ladder_ctrl_reg};
            `CRLC_OFS_PORTF_DIR:   S_AXI_RDATA <= {24'h000000, portf_dir_reg};
            `CRLC_OFS_COMP_MODE:   S_AXI_RDATA <= {29'h00000000, comp_mode_reg};
            // Live tap, comparator, pin and power outputs, plus the sleep input
            `CRLC_OFS_STATUS:      S_AXI_RDATA <= {LADDER_TAP_SELECT, 12'h000, SLEEP_ACTIVE,
                                                   COMP_VINP_FROM_LADDER, PORT_F_PIN5_REF_CONNECT,
                                                   LADDER_POWER_ON};
            default:               S_AXI_RDATA <= 32'h0000_0000;
         endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // Analog controls registered so they never glitch on the ladder
   always @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         LADDER_POWER_ON         <= 1'b0;
         RANGE_LOW_SELECT        <= 1'b0;
         SOURCE_EXTERNAL_SELECT  <= 1'b0;
         LADDER_TAP_SELECT       <= 16'h0000;
         PORT_F_PIN5_REF_CONNECT <= 1'b0;
         COMP_VINP_FROM_LADDER   <= 1'b0;
      end else begin
         // R1 ladder power
         LADDER_POWER_ON        <= ladder_ctrl_reg[`CRLC_BIT_POWER];
         // R3 R4 range of ladder
         RANGE_LOW_SELECT       <= ladder_ctrl_reg[`CRLC_BIT_RANGE_LOW];
         // R5 span source; R11 config is software's task
         SOURCE_EXTERNAL_SELECT <= ladder_ctrl_reg[`CRLC_BIT_SRC_EXT];
         // R6 R14 one-hot taps
         LADDER_TAP_SELECT      <= ladder_ctrl_reg[`CRLC_BIT_POWER] ? tap_onehot(tap_code) : 16'h0000;
         // R2 R10 pin gating
         PORT_F_PIN5_REF_CONNECT <= ladder_ctrl_reg[`CRLC_BIT_PIN_DRIVE] & portf_dir_reg[5];
         // R13 comparator internal reference
         COMP_VINP_FROM_LADDER  <= (comp_mode_reg == `CRLC_MODE_INT_REF);
      end
   end

endmodule // crlc_top

`default_nettype wire

// >>> verilog/crlc_consts.vh
// Constants for the comparator reference ladder control block.
// Assumes an AXI4-Lite master with 32-bit data and a 200 MHz clock.
// How it works
// R1 - Bit 7 powers the ladder when set, powers it down when cleared.
// R2 - Bit 6 routes the ladder level toward port F pin 5.
// R3 - Low range selected: level is tap code over 24 of span.
// R4 - High range: level is quarter span plus tap code over 32.
// R5 - Bit 4 picks external reference pins as span, else supply and ground.
// R6 - Bits 3 to 0 pick one of 16 ladder levels.
// R7 - Reset clears power, pin drive and range bits.
// R8 - Reset also clears the tap code, whole register zero.
// R9 - Waking from sleep leaves the control register unchanged.
// R10 - Pin connects only when direction bit 5 and pin drive both set.
// R11 - Software sets converter reference config before choosing external source.
// R12 - Software should disable the ladder before sleep.
// R13 - Comparator mode 110 applies ladder level to both comparator positive inputs.
// R14 - Range and code decode to one-hot taps, none while powered down. The taps decode the tap code alone; range goes out on RANGE_LOW_SELECT.
`ifndef CRLC_CONSTS_VH
`define CRLC_CONSTS_VH

// Register byte offsets
`define CRLC_OFS_LADDER_CTRL   4'h0
`define CRLC_OFS_PORTF_DIR     4'h4
`define CRLC_OFS_COMP_MODE     4'h8
`define CRLC_OFS_STATUS        4'hc

// Control register fields
`define CRLC_BIT_POWER         7
`define CRLC_BIT_PIN_DRIVE     6
`define CRLC_BIT_RANGE_LOW     5
`define CRLC_BIT_SRC_EXT       4
`define CRLC_TAP_MSB           3

// Reset values
`define CRLC_RST_LADDER_CTRL   8'h00
`define CRLC_RST_PORTF_DIR     8'hff
`define CRLC_RST_COMP_MODE     3'h0

// Comparator mode using internal reference
`define CRLC_MODE_INT_REF      3'h6

// AXI responses
`define CRLC_RESP_OKAY         2'h0
`define CRLC_RESP_SLVERR       2'h2

`endif

// >>> test/crlc_checker.sv
// Checker for the ladder control block, bound to crlc_top.
// Sees only the top ports; write effects are tied to captured data.
`timescale 1ns/10ps
`default_nettype none
module crlc_checker (
   // Bus
   input wire logic REF_CLK, SYS_RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID,
   input wire logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARVALID, S_AXI_ARREADY,
   input wire logic S_AXI_RVALID, S_AXI_RREADY,
   input wire logic [3:0] S_AXI_AWADDR, S_AXI_WSTRB,
   input wire logic [31:0] S_AXI_WDATA, S_AXI_RDATA,
   input wire logic [1:0] S_AXI_BRESP,
   // Ladder controls
   input wire logic LADDER_POWER_ON, RANGE_LOW_SELECT, SOURCE_EXTERNAL_SELECT,
   input wire logic PORT_F_PIN5_REF_CONNECT, COMP_VINP_FROM_LADDER,
   input wire logic [15:0] LADDER_TAP_SELECT
);
   logic [3:0] aw_q;
   logic [7:0] wd_q;
   logic       ws_q;
   // Last accepted write; upper data bits are ignored by the block
   always_ff @(posedge REF_CLK) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) aw_q <= S_AXI_AWADDR;
      if (S_AXI_WVALID && S_AXI_WREADY) wd_q <= S_AXI_WDATA[7:0];
      if (S_AXI_WVALID && S_AXI_WREADY) ws_q <= S_AXI_WSTRB[0];
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   sequence s_ctl; $rose(S_AXI_BVALID) && S_AXI_BRESP == 2'h0 && aw_q == 4'h0 && ws_q; endsequence
   property p_pwr; s_ctl |=> LADDER_POWER_ON == wd_q[7]; endproperty
   a_pwr: assert property (p_pwr) else $error("power output wrong");
   property p_rng; s_ctl |=> RANGE_LOW_SELECT == wd_q[5] && SOURCE_EXTERNAL_SELECT == wd_q[4]; endproperty
   a_rng: assert property (p_rng) else $error("range or source wrong");
   property p_tap; s_ctl |=> LADDER_TAP_SELECT == (wd_q[7] ? 16'h1 << wd_q[3:0] : 16'h0); endproperty
   a_tap: assert property (p_tap) else $error("tap select wrong");
   property p_off; !LADDER_POWER_ON |-> LADDER_TAP_SELECT == 16'h0; endproperty
   a_off: assert property (p_off) else $error("tap while off");
   property p_pin; s_ctl ##0 !wd_q[6] |=> !PORT_F_PIN5_REF_CONNECT; endproperty
   a_pin: assert property (p_pin) else $error("pin connected");
   property p_mode; $rose(S_AXI_BVALID) && aw_q == 4'h8 && ws_q |=> COMP_VINP_FROM_LADDER == (wd_q[2:0] == 3'h6);
   endproperty
   a_mode: assert property (p_mode) else $error("comparator select wrong");
   property p_rd; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
   a_rd: assert property (p_rd) else $error("no read answer");
   property p_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
   a_hold: assert property (p_hold) else $error("read data dropped");
   property p_b; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID; endproperty
   a_b: assert property (p_b) else $error("no write answer");
   c_ctl: cover property (s_ctl);
   c_pin: cover property (PORT_F_PIN5_REF_CONNECT);
   c_cmp: cover property (COMP_VINP_FROM_LADDER);
endmodule // crlc_checker
bind crlc_top crlc_checker i_chk (.*);
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for crlc_top over AXI4-Lite.
// Assumes byte offsets 0x0, 0x4, 0x8, 0xc; low address bits are dropped, so 0x2 aliases 0x0.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic REF_CLK = 0, SYS_RST = 1, SLEEP_ACTIVE = 0;
   logic [3:0] S_AXI_AWADDR = 0, S_AXI_WSTRB = 0, S_AXI_ARADDR = 0;
   logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
   logic [31:0] S_AXI_WDATA = 0;
   wire [31:0] S_AXI_RDATA;
   wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
   wire [15:0] LADDER_TAP_SELECT;
   wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   wire LADDER_POWER_ON, RANGE_LOW_SELECT, SOURCE_EXTERNAL_SELECT, PORT_F_PIN5_REF_CONNECT, COMP_VINP_FROM_LADDER;
   int n_errors = 0, n_compared = 0, cyc = 0, k;
   logic [7:0] v;
   crlc_top i_dut (.*);
   initial forever #2.5 REF_CLK = ~REF_CLK;
   task final_report;
      if (n_errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, e);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Outputs are sampled mid-cycle, where they have settled
   task ck(input logic [20:0] e);
      @(negedge REF_CLK);
      chk({11'h0, LADDER_POWER_ON, RANGE_LOW_SELECT, SOURCE_EXTERNAL_SELECT, PORT_F_PIN5_REF_CONNECT,
           COMP_VINP_FROM_LADDER, LADDER_TAP_SELECT}, {11'h0, e});
   endtask
   // Readies are seen before the edge, so nothing drops early
   task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
      logic ka, kw, kb;
      logic [1:0] rb;
      @(posedge REF_CLK);
      S_AXI_AWADDR <= a; S_AXI_WDATA <= d; S_AXI_WSTRB <= s;
      S_AXI_AWVALID <= 1; S_AXI_WVALID <= 1; S_AXI_BREADY <= 1;
      do begin
         @(negedge REF_CLK);
         ka = S_AXI_AWREADY; kw = S_AXI_WREADY; kb = S_AXI_BVALID; rb = S_AXI_BRESP;
         @(posedge REF_CLK);
         if (ka) S_AXI_AWVALID <= 0;
         if (kw) S_AXI_WVALID <= 0;
      end while (kb !== 1'b1);
      S_AXI_BREADY <= 0;
      chk({30'h0, rb}, {30'h0, r});
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
      logic ka, kv;
      logic [31:0] q;
      logic [1:0] rr;
      @(posedge REF_CLK);
      S_AXI_ARADDR <= a; S_AXI_ARVALID <= 1; S_AXI_RREADY <= 1;
      do begin
         @(negedge REF_CLK);
         ka = S_AXI_ARREADY; kv = S_AXI_RVALID; q = S_AXI_RDATA; rr = S_AXI_RRESP;
         @(posedge REF_CLK);
         if (ka) S_AXI_ARVALID <= 0;
      end while (kv !== 1'b1);
      S_AXI_RREADY <= 0;
      chk(q, e);
      chk({30'h0, rr}, {30'h0, r});
   endtask
   // Hang guard, well above the length of the sequence
   always @(posedge REF_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_errors++;
         $display("Error at %0t: timeout", $time);
         final_report;
      end
   end
   initial begin
      repeat (5) @(posedge REF_CLK);
      SYS_RST <= 0;
      rd(4'h0, 32'h0, 2'h0);
      rd(4'h4, 32'hff, 2'h0);
      ck(21'h0);
      for (k = 0; k < 16; k++) begin
         v = 8'h80 | k[3:0] | {2'b0, k[0], k[1], 4'h0};
         wr(4'h0, {24'h0, v}, 4'h1, 2'h0);
         ck({1'b1, k[0], k[1], 2'b00, 16'h1 << k});
      end
      wr(4'h0, 32'hffffff0f, 4'h1, 2'h0);
      ck(21'h0);
      rd(4'h0, 32'h0f, 2'h0);
      wr(4'h0, 32'hc3, 4'h0, 2'h0);
      rd(4'h0, 32'h0f, 2'h0);
      wr(4'h0, 32'hc3, 4'h1, 2'h0);
      ck({5'b10010, 16'h0008});
      wr(4'h4, 32'hdf, 4'h1, 2'h0);
      ck({5'b10000, 16'h0008});
      wr(4'h4, 32'h20, 4'h1, 2'h0);
      ck({5'b10010, 16'h0008});
      for (k = 0; k < 8; k++) begin
         wr(4'h8, k, 4'h1, 2'h0);
         ck({4'b1001, k == 6, 16'h0008});
      end
      rd(4'hc, 32'h00080003, 2'h0);
      wr(4'h0, 32'h43, 4'h1, 2'h0);
      @(posedge REF_CLK) SLEEP_ACTIVE <= 1;
      rd(4'h0, 32'h43, 2'h0);
      rd(4'hc, 32'h0000000a, 2'h0);
      SLEEP_ACTIVE <= 0;
      wr(4'h0, 32'hc3, 4'h1, 2'h0);
      rd(4'h2, 32'hc3, 2'h0);
      wr(4'h2, 32'hc3, 4'h1, 2'h0);
      rd(4'h0, 32'hc3, 2'h0);
      @(posedge REF_CLK) SYS_RST <= 1;
      @(posedge REF_CLK) SYS_RST <= 0;
      rd(4'h0, 32'h0, 2'h0);
      rd(4'h4, 32'hff, 2'h0);
      ck(21'h0);
      final_report;
   end
endmodule // testbench
`default_nettype wire
